// File: design/agu_consts.svh
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

`define OFS_CTRL 12'h000
`define OFS_X_START 12'h004
`define OFS_X_END 12'h008
`define OFS_Y_START 12'h00C
`define OFS_Y_END 12'h010
`define OFS_BITREV 12'h014
`define OFS_STATUS 12'h018

`define CTRL_XSEL_MSB 3
`define CTRL_XSEL_LSB 0
`define CTRL_YSEL_MSB 7
`define CTRL_YSEL_LSB 4
`define CTRL_BSEL_MSB 11
`define CTRL_BSEL_LSB 8
`define CTRL_YEN_BIT 14
`define CTRL_XEN_BIT 15
`define CTRL_WMASK 16'hCFFF
`define BREV_EN_BIT 15
`define BREV_PIVOT_MSB 14

`define CTRL_RESET 16'h0000
`define START_RESET 16'h0000
`define END_RESET 16'h0001
`define BREV_RESET 16'h0000

`define SEL_OFF 4'hF
`define W0_NUM 4'h0
`define X_MAC_LO 4'h8
`define X_MAC_IDX 4'h9
`define Y_MAC_LO 4'hA
`define Y_MAC_IDX 4'hB
`define NEAR_BITS 13
`define STEP_P2 16'h0002
`define STEP_P4 16'h0004
`define STEP_P6 16'h0006
`define STEP_N2 16'hFFFE
`define STEP_N4 16'hFFFC
`define STEP_N6 16'hFFFA
`endif

// File: design/agu_pkg.sv
package agu_pkg;
	typedef enum logic [2:0] {
		MODE_FILE_NEAR = 3'b000,
		MODE_FILE_FULL = 3'b001,
		MODE_INDIRECT = 3'b010,
		MODE_POST_MOD = 3'b011,
		MODE_PRE_MOD = 3'b100,
		MODE_REG_OFS = 3'b101,
		MODE_LIT_OFS = 3'b110,
		MODE_DIRECT = 3'b111
	} agu_mode_e;

	typedef enum logic [2:0] {
		LIT_5 = 3'b000,
		LIT_8 = 3'b001,
		LIT_10 = 3'b010,
		LIT_14 = 3'b011,
		LIT_16S = 3'b100
	} lit_kind_e;

	typedef struct packed {
		logic [15:0] ea;
		logic wb_en;
		logic [15:0] wb_val;
	} agu_result_s;
endpackage : agu_pkg

// File: design/address_generation_modulo.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "agu_consts.svh"
module address_generation_modulo (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic x_req_valid,
	input wire agu_pkg::agu_mode_e x_req_mode,
	input wire logic [3:0] x_req_ptr_num,
	input wire logic [15:0] x_req_ptr_val,
	input wire logic [15:0] x_req_ofs,
	input wire logic x_req_write,
	input wire logic x_req_word,
	input wire logic x_req_prog,
	input wire logic x_req_mac,
	input wire logic [3:0] x_req_dest_num,
	input wire agu_pkg::lit_kind_e x_req_lit_kind,
	input wire logic [15:0] x_req_lit_raw,
	output logic x_ea_valid,
	output logic [15:0] x_ea,
	output logic x_wb_en,
	output logic [3:0] x_wb_num,
	output logic [15:0] x_wb_val,
	output logic [3:0] x_res_num,
	output logic [15:0] x_literal,
	output logic x_err,
	input wire logic y_req_valid,
	input wire agu_pkg::agu_mode_e y_req_mode,
	input wire logic [3:0] y_req_ptr_num,
	input wire logic [15:0] y_req_ptr_val,
	input wire logic [15:0] y_req_ofs,
	output logic y_ea_valid,
	output logic [15:0] y_ea,
	output logic y_wb_en,
	output logic [3:0] y_wb_num,
	output logic [15:0] y_wb_val,
	output logic y_err
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function automatic logic [15:0] bit_rev16(input logic [15:0] v);
	logic [15:0] r;
	r = 16'h0000;
	for (int i = 0; i < 16; i++)
	begin
		r[i] = v[15 - i];
	end
	return r;
endfunction : bit_rev16

function automatic logic reg_known(input logic [11:0] a);
	return (a == `OFS_CTRL) || (a == `OFS_X_START) || (a == `OFS_X_END) ||
		(a == `OFS_Y_START) || (a == `OFS_Y_END) || (a == `OFS_BITREV) ||
		(a == `OFS_STATUS);
endfunction : reg_known

// legal pointer and mode set of the dual-operand class, for either space
function automatic logic mac_ok(input agu_pkg::agu_mode_e mode, input logic [3:0] num,
	input logic [15:0] step, input logic [3:0] lo, input logic [3:0] idx);
	logic step_ok;
	step_ok = (step == `STEP_P2) || (step == `STEP_P4) || (step == `STEP_P6) ||
		(step == `STEP_N2) || (step == `STEP_N4) || (step == `STEP_N6);
	return ((num == lo) || (num == idx)) &&
		((mode == agu_pkg::MODE_INDIRECT) ||
		((mode == agu_pkg::MODE_REG_OFS) && (num == idx)) ||
		((mode == agu_pkg::MODE_POST_MOD) && step_ok));
endfunction : mac_ok

// shared by both spaces; the step sign chooses which limit a one-way buffer checks
function automatic agu_pkg::agu_result_s agu_calc(input agu_pkg::agu_mode_e mode,
	input logic [15:0] ptr, input logic [15:0] ofs, input logic [15:0] lo_lim,
	input logic [15:0] hi_lim, input logic circ, input logic wordonly);
	agu_pkg::agu_result_s r;
	logic [15:0] sum;
	logic [15:0] wrapped;
	logic [16:0] len;
	logic pow2;
	logic chk_hi;
	logic chk_lo;
	sum = ptr + ofs;
	len = {1'b0, hi_lim} - {1'b0, lo_lim} + 17'h00001;
	pow2 = ((len & (len - 17'h00001)) == 17'h00000);
	chk_hi = !ofs[15] || pow2;
	chk_lo = ofs[15] || pow2;
	wrapped = sum;
	if (circ && chk_hi && (sum > hi_lim))
	begin
		wrapped = sum - len[15:0];
	end
	else if (circ && chk_lo && (sum < lo_lim))
	begin
		wrapped = sum + len[15:0];
	end
	r.ea = 16'h0000;
	r.wb_en = 1'b0;
	r.wb_val = ptr;
	case (mode)
		agu_pkg::MODE_FILE_NEAR: r.ea = {3'h0, ofs[`NEAR_BITS-1:0]};
		agu_pkg::MODE_FILE_FULL: r.ea = ofs;
		agu_pkg::MODE_INDIRECT: r.ea = ptr;
		agu_pkg::MODE_POST_MOD:
		begin
			r.ea = ptr;
			r.wb_en = 1'b1;
			r.wb_val = wrapped;
		end
		agu_pkg::MODE_PRE_MOD:
		begin
			r.ea = wrapped;
			r.wb_en = 1'b1;
			r.wb_val = wrapped;
		end
		agu_pkg::MODE_REG_OFS: r.ea = wrapped;
		agu_pkg::MODE_LIT_OFS: r.ea = wrapped;
		default: r.ea = 16'h0000;
	endcase
	if (wordonly)
	begin
		r.ea[0] = 1'b0;
		r.wb_val[0] = 1'b0;
	end
	return r;
endfunction : agu_calc

////////////////////////////////////////////////////////////////////////////////
// register file

logic [15:0] ctrl_reg;
logic [15:0] x_start_reg;
logic [15:0] x_end_reg;
logic [15:0] y_start_reg;
logic [15:0] y_end_reg;
logic [15:0] bitrev_reg;
logic [31:0] prdata_reg;
logic [31:0] prdata_next;
logic wr_strobe;
logic rd_setup;

assign wr_strobe = psel && penable && pwrite;
assign rd_setup = psel && !penable && !pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && !reg_known(paddr);
assign prdata = prdata_reg;

// bound registers hold word addresses: start bit 0 reads 0, end bit 0 reads 1
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ctrl_reg <= `CTRL_RESET;
		x_start_reg <= `START_RESET;
		x_end_reg <= `END_RESET;
		y_start_reg <= `START_RESET;
		y_end_reg <= `END_RESET;
		bitrev_reg <= `BREV_RESET;
	end
	else if (wr_strobe)
	begin
		case (paddr)
			`OFS_CTRL: ctrl_reg <= pwdata[15:0] & `CTRL_WMASK;
			`OFS_X_START: x_start_reg <= {pwdata[15:1], 1'b0};
			`OFS_X_END: x_end_reg <= {pwdata[15:1], 1'b1};
			`OFS_Y_START: y_start_reg <= {pwdata[15:1], 1'b0};
			`OFS_Y_END: y_end_reg <= {pwdata[15:1], 1'b1};
			`OFS_BITREV: bitrev_reg <= pwdata[15:0];
			default: ctrl_reg <= ctrl_reg;
		endcase
	end
end

always_comb
begin
	case (paddr)
		`OFS_CTRL: prdata_next = {16'h0000, ctrl_reg};
		`OFS_X_START: prdata_next = {16'h0000, x_start_reg};
		`OFS_X_END: prdata_next = {16'h0000, x_end_reg};
		`OFS_Y_START: prdata_next = {16'h0000, y_start_reg};
		`OFS_Y_END: prdata_next = {16'h0000, y_end_reg};
		`OFS_BITREV: prdata_next = {16'h0000, bitrev_reg};
		`OFS_STATUS: prdata_next = {y_ea, x_ea};
		default: prdata_next = 32'h00000000;
	endcase
end

// data is fetched in the setup cycle so the zero-wait access phase sees it
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata_reg <= 32'h00000000;
	end
	else if (rd_setup)
	begin
		prdata_reg <= prdata_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// X generator (read and write paths, program space pointers)

logic [3:0] x_sel;
logic [3:0] y_sel;
logic [3:0] b_sel;
logic x_bitrev_act;
logic x_circ_act;
logic x_bad;
logic [15:0] x_rev_sum;
agu_pkg::agu_result_s x_res;
logic [15:0] x_ea_next;
logic [15:0] x_wbv_next;
logic [15:0] lit_next;

assign x_sel = ctrl_reg[`CTRL_XSEL_MSB:`CTRL_XSEL_LSB];
assign y_sel = ctrl_reg[`CTRL_YSEL_MSB:`CTRL_YSEL_LSB];
assign b_sel = ctrl_reg[`CTRL_BSEL_MSB:`CTRL_BSEL_LSB];

// bit-reversed only for word writes to data space with an increment step
assign x_bitrev_act = bitrev_reg[`BREV_EN_BIT] && (b_sel != `SEL_OFF) &&
	(b_sel == x_req_ptr_num) && x_req_write && x_req_word && !x_req_prog &&
	((x_req_mode == agu_pkg::MODE_PRE_MOD) || (x_req_mode == agu_pkg::MODE_POST_MOD)) &&
	!x_req_ofs[15];
assign x_circ_act = ctrl_reg[`CTRL_XEN_BIT] && (x_sel != `SEL_OFF) &&
	(x_sel == x_req_ptr_num) && !x_bitrev_act;
assign x_bad = x_req_mac && !mac_ok(x_req_mode, x_req_ptr_num, x_req_ofs,
	`X_MAC_LO, `X_MAC_IDX);
assign x_rev_sum = bit_rev16(bit_rev16(x_req_ptr_val) +
	bit_rev16({bitrev_reg[`BREV_PIVOT_MSB:0], 1'b0}));
assign x_res = agu_calc(x_req_mode, x_req_ptr_val, x_req_ofs, x_start_reg, x_end_reg,
	x_circ_act, 1'b0);

always_comb
begin
	x_ea_next = x_res.ea;
	x_wbv_next = x_res.wb_val;
	if (x_bitrev_act)
	begin
		x_wbv_next = {x_rev_sum[15:1], 1'b0};
		x_ea_next = (x_req_mode == agu_pkg::MODE_PRE_MOD) ? x_wbv_next :
			{x_req_ptr_val[15:1], 1'b0};
	end
end

always_comb
begin
	case (x_req_lit_kind)
		agu_pkg::LIT_5: lit_next = {11'h000, x_req_lit_raw[4:0]};
		agu_pkg::LIT_8: lit_next = {8'h00, x_req_lit_raw[7:0]};
		agu_pkg::LIT_10: lit_next = {6'h00, x_req_lit_raw[9:0]};
		agu_pkg::LIT_14: lit_next = {2'h0, x_req_lit_raw[13:0]};
		agu_pkg::LIT_16S: lit_next = x_req_lit_raw;
		default: lit_next = 16'h0000;
	endcase
end

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		x_ea_valid <= 1'b0;
		x_ea <= 16'h0000;
		x_wb_en <= 1'b0;
		x_wb_num <= 4'h0;
		x_wb_val <= 16'h0000;
		x_res_num <= 4'h0;
		x_literal <= 16'h0000;
		x_err <= 1'b0;
	end
	else
	begin
		x_ea_valid <= x_req_valid && !x_bad;
		x_err <= x_req_valid && x_bad;
		x_wb_en <= x_req_valid && !x_bad && (x_res.wb_en || x_bitrev_act);
		if (x_req_valid)
		begin
			x_ea <= x_ea_next;
			x_wb_num <= x_req_ptr_num;
			x_wb_val <= x_wbv_next;
			x_literal <= lit_next;
			x_res_num <= ((x_req_mode == agu_pkg::MODE_FILE_NEAR) ||
				(x_req_mode == agu_pkg::MODE_FILE_FULL)) ? `W0_NUM : x_req_dest_num;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Y generator (dual-operand word reads only)

logic y_circ_act;
logic y_bad;
agu_pkg::agu_result_s y_res;

assign y_circ_act = ctrl_reg[`CTRL_YEN_BIT] && (y_sel != `SEL_OFF) &&
	(y_sel == y_req_ptr_num);
assign y_bad = !mac_ok(y_req_mode, y_req_ptr_num, y_req_ofs, `Y_MAC_LO, `Y_MAC_IDX);
assign y_res = agu_calc(y_req_mode, y_req_ptr_val, y_req_ofs, y_start_reg, y_end_reg,
	y_circ_act, 1'b1);

always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		y_ea_valid <= 1'b0;
		y_ea <= 16'h0000;
		y_wb_en <= 1'b0;
		y_wb_num <= 4'h0;
		y_wb_val <= 16'h0000;
		y_err <= 1'b0;
	end
	else
	begin
		y_ea_valid <= y_req_valid && !y_bad;
		y_err <= y_req_valid && y_bad;
		y_wb_en <= y_req_valid && !y_bad && y_res.wb_en;
		if (y_req_valid)
		begin
			y_ea <= y_res.ea;
			y_wb_num <= y_req_ptr_num;
			y_wb_val <= y_res.wb_val;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);

logic [15:0] x_sum_chk;
logic [16:0] x_len_chk;
assign x_sum_chk = x_req_ptr_val + x_req_ofs;
assign x_len_chk = {1'b0, x_end_reg} - {1'b0, x_start_reg} + 17'h00001;

sequence x_ok_req_s(agu_pkg::agu_mode_e m);
	x_req_valid && !x_bad && (x_req_mode == m);
endsequence

sequence x_plain_req_s(agu_pkg::agu_mode_e m);
	x_ok_req_s(m) ##0 (!x_circ_act && !x_bitrev_act);
endsequence

x_answer_a: assert property (x_req_valid |=> (x_ea_valid != x_err))
	else $error("x generator did not answer one cycle after a request");
y_word_a: assert property (y_ea_valid |-> !y_ea[0] && (!y_wb_en || !y_wb_val[0]))
	else $error("y address has bit 0 set");
near_file_a: assert property (x_ok_req_s(agu_pkg::MODE_FILE_NEAR) |=>
	(x_ea[15:13] == 3'h0) && (x_res_num == `W0_NUM))
	else $error("near file address escapes 8192 bytes");
offset_keep_a: assert property ((x_ok_req_s(agu_pkg::MODE_REG_OFS) or
	x_ok_req_s(agu_pkg::MODE_LIT_OFS)) |=> x_ea_valid && !x_wb_en)
	else $error("offset mode wrote the pointer back");
post_mod_a: assert property (x_plain_req_s(agu_pkg::MODE_POST_MOD) |=>
	(x_ea == $past(x_req_ptr_val)) && x_wb_en && (x_wb_val == $past(x_sum_chk)))
	else $error("post-modify address or update wrong");
reg_ofs_a: assert property (x_plain_req_s(agu_pkg::MODE_REG_OFS) |=>
	x_ea == $past(x_sum_chk))
	else $error("register offset sum wrong");
y_ptr_set_a: assert property (y_req_valid && (y_req_ptr_num != `Y_MAC_LO) &&
	(y_req_ptr_num != `Y_MAC_IDX) |=> y_err && !y_ea_valid)
	else $error("y accepted a pointer outside ten and eleven");
y_index_a: assert property (y_req_valid && (y_req_mode == agu_pkg::MODE_REG_OFS) &&
	(y_req_ptr_num == `Y_MAC_LO) |=> y_err)
	else $error("y indexed mode accepted register ten");
x_sel_off_a: assert property (x_ok_req_s(agu_pkg::MODE_POST_MOD) ##0 (!x_bitrev_act &&
	((x_sel == `SEL_OFF) || !ctrl_reg[`CTRL_XEN_BIT])) |=> x_wb_val == $past(x_sum_chk))
	else $error("x circular active while disabled");
wrap_end_a: assert property (x_ok_req_s(agu_pkg::MODE_PRE_MOD) ##0 (x_circ_act &&
	!x_req_ofs[15] && (x_sum_chk > x_end_reg)) |=>
	x_wb_val == 16'($past(x_sum_chk) - $past(x_len_chk)))
	else $error("x end boundary wrap wrong");

endmodule : address_generation_modulo

// File: sim/decoder_model.sv
`timescale 1ns/1ps
module decoder_model (
	input wire logic pclk,
	output agu_pkg::agu_mode_e x_req_mode,
	output logic x_req_valid,
	output logic [3:0] x_req_ptr_num,
	output logic [15:0] x_req_ptr_val,
	output logic [15:0] x_req_ofs,
	output logic x_req_write,
	output logic x_req_word,
	output logic x_req_prog,
	output logic x_req_mac,
	output logic [3:0] x_req_dest_num,
	output agu_pkg::lit_kind_e x_req_lit_kind,
	output logic [15:0] x_req_lit_raw,
	output logic y_req_valid,
	output agu_pkg::agu_mode_e y_req_mode,
	output logic [3:0] y_req_ptr_num,
	output logic [15:0] y_req_ptr_val,
	output logic [15:0] y_req_ofs
);
	initial
	begin
		{x_req_valid, x_req_write, x_req_word, x_req_prog, x_req_mac} = 5'h00;
		{x_req_ptr_num, x_req_ptr_val, x_req_ofs, x_req_dest_num, x_req_lit_raw} = 56'h0;
		x_req_mode = agu_pkg::MODE_INDIRECT;
		x_req_lit_kind = agu_pkg::LIT_5;
		{y_req_valid, y_req_ptr_num, y_req_ptr_val, y_req_ofs} = 37'h0;
		y_req_mode = agu_pkg::MODE_INDIRECT;
	end

	////////////////////////////////////////////////////////////////////////////////
	// callers also pass dual-operand pointers from outside their space to check the error flag, and avoid the stack pointers
	task automatic send_x(input agu_pkg::agu_mode_e m, input logic [3:0] n,
		input logic [15:0] v, input logic [15:0] o, input logic mac,
		input agu_pkg::lit_kind_e k, input logic [3:0] d, input logic [15:0] r,
		input logic [2:0] wp);
		@(posedge pclk);
		x_req_valid <= 1'b1;
		{x_req_mode, x_req_ptr_num, x_req_ptr_val, x_req_ofs, x_req_mac} <= {m, n, v, o, mac};
		{x_req_lit_kind, x_req_dest_num, x_req_lit_raw} <= {k, d, r};
		{x_req_write, x_req_word, x_req_prog} <= wp;
		@(posedge pclk);
		x_req_valid <= 1'b0;
		// released pointer value, offset and literal fields move so a stale value cannot pass for a held one
		{x_req_ptr_val, x_req_ofs, x_req_lit_raw} <= {~v, ~o, ~r};
	endtask : send_x

	task automatic send_y(input agu_pkg::agu_mode_e m, input logic [3:0] n,
		input logic [15:0] v, input logic [15:0] o);
		@(posedge pclk);
		y_req_valid <= 1'b1;
		{y_req_mode, y_req_ptr_num, y_req_ptr_val, y_req_ofs} <= {m, n, v, o};
		@(posedge pclk);
		y_req_valid <= 1'b0;
		{y_req_ptr_val, y_req_ofs} <= {~v, ~o};
	endtask : send_y
endmodule : decoder_model

// File: sim/test_address_generation_modulo.sv
`timescale 1ns/1ps
module test_address_generation_modulo;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic x_req_valid, x_req_write, x_req_word, x_req_prog, x_req_mac;
	logic y_req_valid, x_ea_valid, x_wb_en, x_err, y_ea_valid, y_wb_en, y_err;
	agu_pkg::agu_mode_e x_req_mode, y_req_mode;
	agu_pkg::lit_kind_e x_req_lit_kind;
	logic [3:0] x_req_ptr_num, x_req_dest_num, y_req_ptr_num, x_wb_num, x_res_num, y_wb_num;
	logic [15:0] x_req_ptr_val, x_req_ofs, x_req_lit_raw, y_req_ptr_val, y_req_ofs;
	logic [15:0] x_ea, x_wb_val, x_literal, y_ea, y_wb_val;
	int miscompares, checked, cycles;
	int xs, xe, ys, ye, last_x, last_y;
	int wwp_force = -1;
	bit xen, yen, bren;
	bit [3:0] xsel, ysel, bsel;
	bit [14:0] piv;
	int rst_val[7] = '{0, 0, 1, 0, 1, 0, 0};
	int lit_mask[5] = '{32'h1F, 32'hFF, 32'h3FF, 32'h3FFF, 32'hFFFF};

	address_generation_modulo i_address_generation_modulo (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .x_req_valid, .x_req_mode,
		.x_req_ptr_num, .x_req_ptr_val, .x_req_ofs, .x_req_write, .x_req_word, .x_req_prog,
		.x_req_mac, .x_req_dest_num, .x_req_lit_kind, .x_req_lit_raw, .x_ea_valid, .x_ea,
		.x_wb_en, .x_wb_num, .x_wb_val, .x_res_num, .x_literal, .x_err, .y_req_valid,
		.y_req_mode, .y_req_ptr_num, .y_req_ptr_val, .y_req_ofs, .y_ea_valid, .y_ea, .y_wb_en,
		.y_wb_num, .y_wb_val, .y_err);
	decoder_model i_decoder_model (.pclk, .x_req_mode, .x_req_valid, .x_req_ptr_num,
		.x_req_ptr_val, .x_req_ofs, .x_req_write, .x_req_word, .x_req_prog, .x_req_mac,
		.x_req_dest_num, .x_req_lit_kind, .x_req_lit_raw, .y_req_valid, .y_req_mode,
		.y_req_ptr_num, .y_req_ptr_val, .y_req_ofs);

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		case (a)
			12'h000: {xen, yen, bsel, ysel, xsel} = {d[15], d[14], d[11:8], d[7:4], d[3:0]};
			12'h004: xs = {d[15:1], 1'b0};
			12'h008: xe = {d[15:1], 1'b1};
			12'h00C: ys = {d[15:1], 1'b0};
			12'h010: ye = {d[15:1], 1'b1};
			12'h014: {bren, piv} = d[15:0];
			default: ;
		endcase
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic er_exp);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp);
		chk(er, er_exp);
	endtask : rdchk

	function automatic int rev16(int v);
		int r;
		r = 0;
		for (int i = 0; i < 16; i++)
			r[15 - i] = v[i];
		return r;
	endfunction : rev16

	////////////////////////////////////////////////////////////////////////////////
	function automatic int wrapv(int v, int o, int s, int e);
		int len;
		bit p2;
		len = e - s + 1;
		p2 = (len & (len - 1)) == 0;
		if (v > e && (o < 32768 || p2))
			return v - len;
		if (v < s && (o >= 32768 || p2))
			return v + len;
		return v;
	endfunction : wrapv

	function automatic bit illegal(bit y, int m, int n, int o);
		int lo;
		lo = y ? 10 : 8;
		if (n != lo && n != lo + 1)
			return 1;
		if (m == agu_pkg::MODE_REG_OFS)
			return n == lo;
		if (m == agu_pkg::MODE_POST_MOD)
			return !(o inside {2, 4, 6, 32'hFFFE, 32'hFFFC, 32'hFFFA});
		return m != agu_pkg::MODE_INDIRECT;
	endfunction : illegal

	task automatic xreq(input bit y, input agu_pkg::agu_mode_e m, input int n, input int v,
		input int o, input bit mac);
		int ea, wb, k, d, r, w;
		bit we, bad, circ, brev;
		logic [2:0] wwp;
		k = $urandom_range(4);
		d = $urandom_range(15);
		r = $urandom_range(16'hFFFF);
		bad = (mac || y) && illegal(y, m, n, o);
		circ = y ? (yen && ysel != 15 && ysel == n) : (xen && xsel != 15 && xsel == n);
		w = (v + o) & 16'hFFFF;
		if (circ)
			w = y ? wrapv(w, o, ys, ye) : wrapv(w, o, xs, xe);
		case (m)
			agu_pkg::MODE_FILE_NEAR: ea = o & 16'h1FFF;
			agu_pkg::MODE_FILE_FULL: ea = o;
			agu_pkg::MODE_DIRECT: ea = 0;
			agu_pkg::MODE_INDIRECT, agu_pkg::MODE_POST_MOD: ea = v;
			default: ea = w;
		endcase
		we = m == agu_pkg::MODE_POST_MOD || m == agu_pkg::MODE_PRE_MOD;
		wb = y ? w & 16'hFFFE : w;
		ea = y ? ea & 16'hFFFE : ea;
		wwp = wwp_force < 0 ? 3'($urandom) : 3'(wwp_force);
		// word data write with an increment step on the bit-reversed pointer
		brev = !y && bren && bsel != 15 && bsel == n && wwp == 3'b110 && we && o < 32768;
		if (brev)
		begin
			wb = rev16(rev16(v) + rev16(piv * 2)) & 16'hFFFE;
			ea = m == agu_pkg::MODE_PRE_MOD ? wb : v & 16'hFFFE;
		end
		if (y)
			last_y = ea;
		else
			last_x = ea;
		if (y)
			i_decoder_model.send_y(m, 4'(n), 16'(v), 16'(o));
		else
			i_decoder_model.send_x(m, 4'(n), 16'(v), 16'(o), mac,
				agu_pkg::lit_kind_e'(k[2:0]), 4'(d), 16'(r), wwp);
		#1;
		chk(y ? y_err : x_err, bad);
		chk(y ? y_ea_valid : x_ea_valid, !bad);
		if (!bad)
		begin
			chk(y ? y_ea : x_ea, ea);
			chk(y ? y_wb_en : x_wb_en, we);
			if (we)
				chk(y ? {y_wb_num, y_wb_val} : {x_wb_num, x_wb_val}, {n[3:0], wb[15:0]});
			if (!y)
				chk({x_res_num, x_literal}, {m <= agu_pkg::MODE_FILE_FULL ? 4'h0 : 4'(d),
					16'(r & lit_mask[k])});
		end
	endtask : xreq

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(93084));
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_val[i]) rdchk(12'(4 * i), rst_val[i], 1'b0);
		wr(12'h01C, 32'h0000_FFFF);
		rdchk(12'h01C, 32'h0, 1'b1);
		wr(12'h000, 32'hFFFF_FFFF);
		rdchk(12'h000, 32'h0000_CFFF, 1'b0);
		wr(12'h000, 32'h0);
		repeat (16) xreq(0, agu_pkg::agu_mode_e'($urandom_range(7)), $urandom_range(13),
			$urandom_range(16'hFFFF), $urandom_range(16'hFFFF), 0);
		// power-of-two X buffer, 32 bytes, pointer register three
		wr(12'h000, 32'h8003);
		wr(12'h004, 32'h1000);
		wr(12'h008, 32'h101F);
		xreq(0, agu_pkg::MODE_POST_MOD, 3, 16'h101E, 16'h0006, 0);
		xreq(0, agu_pkg::MODE_PRE_MOD, 3, 16'h1002, 16'hFFFA, 0);
		xreq(0, agu_pkg::MODE_LIT_OFS, 3, 16'h101C, 16'h0008, 0);
		xreq(0, agu_pkg::MODE_REG_OFS, 3, 16'h1010, 16'h0014, 0);
		xreq(0, agu_pkg::MODE_POST_MOD, 4, 16'h101E, 16'h0006, 0);
		wr(12'h008, 32'h1017);
		xreq(0, agu_pkg::MODE_POST_MOD, 3, 16'h1016, 16'h0002, 0);
		xreq(0, agu_pkg::MODE_PRE_MOD, 3, 16'h1000, 16'hFFFE, 0);
		xreq(0, agu_pkg::MODE_PRE_MOD, 3, 16'h1016, 16'h0004, 0);
		xreq(0, agu_pkg::MODE_POST_MOD, 3, 16'h0FF0, 16'h0002, 0);
		wr(12'h000, 32'h800F);
		xreq(0, agu_pkg::MODE_POST_MOD, 15, 16'h1016, 16'h0004, 0);
		wr(12'h000, 32'h0003);
		xreq(0, agu_pkg::MODE_POST_MOD, 3, 16'h1016, 16'h0004, 0);
		xreq(0, agu_pkg::MODE_POST_MOD, 9, 16'h0800, 16'h0006, 1);
		xreq(0, agu_pkg::MODE_INDIRECT, 10, 16'h0800, 16'h0000, 1);
		xreq(0, agu_pkg::MODE_REG_OFS, 8, 16'h0800, 16'h0004, 1);
		xreq(0, agu_pkg::MODE_REG_OFS, 9, 16'h0800, 16'h0004, 1);
		xreq(0, agu_pkg::MODE_POST_MOD, 8, 16'h0800, 16'h0003, 1);
		xreq(0, agu_pkg::MODE_PRE_MOD, 8, 16'h0800, 16'h0002, 1);
		// bit-reversed writes on pointer five, which is also the X circular pointer, then a word read and a program-space write that wrap circularly
		wr(12'h014, 32'h8008);
		wr(12'h000, 32'h8505);
		wwp_force = 6;
		xreq(0, agu_pkg::MODE_POST_MOD, 5, 16'h1016, 16'h0002, 0);
		xreq(0, agu_pkg::MODE_PRE_MOD, 5, 16'h1000, 16'h0002, 0);
		wwp_force = 2;
		xreq(0, agu_pkg::MODE_POST_MOD, 5, 16'h1016, 16'h0002, 0);
		wwp_force = 7;
		xreq(0, agu_pkg::MODE_POST_MOD, 5, 16'h1016, 16'h0002, 0);
		wwp_force = -1;
		// Y buffer of 16 bytes on pointer register ten
		wr(12'h000, 32'h40A0);
		wr(12'h00C, 32'h2000);
		wr(12'h010, 32'h200F);
		xreq(1, agu_pkg::MODE_POST_MOD, 10, 16'h200E, 16'h0004, 1);
		xreq(1, agu_pkg::MODE_POST_MOD, 10, 16'h2000, 16'hFFFA, 1);
		xreq(1, agu_pkg::MODE_INDIRECT, 11, 16'h2005, 16'h0000, 1);
		xreq(1, agu_pkg::MODE_REG_OFS, 11, 16'h2000, 16'h0003, 1);
		xreq(1, agu_pkg::MODE_INDIRECT, 8, 16'h2000, 16'h0000, 1);
		xreq(1, agu_pkg::MODE_REG_OFS, 10, 16'h2000, 16'h0002, 1);
		xreq(1, agu_pkg::MODE_POST_MOD, 11, 16'h2000, 16'h0003, 1);
		repeat (10) xreq(1, agu_pkg::agu_mode_e'($urandom_range(7)), 8 + $urandom_range(3),
			16'h2000 + $urandom_range(16'h0FF), 2 * $urandom_range(3), 1);
		rdchk(12'h018, {16'(last_y), 16'(last_x)}, 1'b0);
		close_out();
	end
endmodule : test_address_generation_modulo
